/* verilog/srsc_top.v */
// smart reset scope controller with avalon register slave
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "srsc_consts.vh"
module srsc_top (
    // clock and power-on reset
    input  wire        sys_clk_in,
    input  wire        resetn_in,
    // avalon-mm slave
    input  wire [3:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    output reg  [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out,
    // monitor inputs (asynchronous)
    input  wire        reg5v_overvolt_in,
    input  wire        battery_overvolt_in,
    input  wire        watchdog_expire_in,
    // reset pin, open drain
    input  wire        rst_pin_n_in,
    output wire        rst_pin_out,
    output wire        rst_pin_oe_out,
    // domain reset pulses, active high, then the output disable and regulator off levels
    output reg         cfg_reset_out,
    output reg         drv_reset_out,
    output reg         lb_drv_reset_out,
    output reg         lb_cfg_reset_out,
    output reg         watchdog_reset_out,
    output reg         xcvr_reset_out,
    output reg         output_disable_bit_out,
    output reg         vreg_off_out,
    // interrupt
    output wire        irq_out
);
    // synchronisers
    reg [1:0] sync_r5, sync_bov, sync_wd, sync_pin;
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_r5  <= 2'b00;
            sync_bov <= 2'b00;
            sync_wd  <= 2'b00;
            sync_pin <= 2'b11;
        end else begin
            sync_r5  <= {sync_r5[0], reg5v_overvolt_in};
            sync_bov <= {sync_bov[0], battery_overvolt_in};
            sync_wd  <= {sync_wd[0], watchdog_expire_in};
            sync_pin <= {sync_pin[0], rst_pin_n_in};
        end
    end
    wire r5   = sync_r5[1];
    wire bov  = sync_bov[1];
    wire wd   = sync_wd[1];
    reg  drive_low;
    // own drive must not count as an external hold
    wire ext_low = !sync_pin[1] && !drive_low;

    wire [`SRSC_CNT_W-1:0] bov_cnt;
    wire [`SRSC_CNT_W-1:0] pin_cnt;
    srsc_filter u_bov_flt (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .level_in   (bov),
        .count_out  (bov_cnt)
    );
    srsc_filter u_pin_flt (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .level_in   (ext_low),
        .count_out  (pin_cnt)
    );

    // edge and end detection
    reg r5_d, wd_d, bov_d, ext_d;
    reg [`SRSC_CNT_W-1:0] pin_cnt_d;
    reg [`SRSC_CNT_W-1:0] bov_cnt_d;
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r5_d      <= 1'b0;
            wd_d      <= 1'b0;
            bov_d     <= 1'b0;
            ext_d     <= 1'b0;
            pin_cnt_d <= {`SRSC_CNT_W{1'b0}};
            bov_cnt_d <= {`SRSC_CNT_W{1'b0}};
        end else begin
            r5_d      <= r5;
            wd_d      <= wd;
            bov_d     <= bov;
            ext_d     <= ext_low;
            pin_cnt_d <= pin_cnt;
            bov_cnt_d <= bov_cnt;
        end
    end
    wire ev_r5    = r5 && !r5_d;
    wire ev_wd    = wd && !wd_d;
    wire bov_end  = !bov && bov_d;
    // mid-length overvoltage judged when it ends
    wire ev_bov1  = bov_end && (bov_cnt_d > `SRSC_OV1_CYC) && (bov_cnt_d <= `SRSC_OV2_CYC);
    wire ev_bov2  = bov && (bov_cnt == `SRSC_OV2_CYC + 32'd1);
    wire pin_ok   = pin_cnt_d > `SRSC_RSTFLT_CYC;
    wire pin_end  = !ext_low && ext_d && pin_ok;
    wire ev_pins  = pin_end && (pin_cnt_d <= `SRSC_HOLD_CYC);
    wire ev_pinl  = ext_low && (pin_cnt == `SRSC_HOLD_CYC + 32'd1);

    // register file
    reg  [`SRSC_EV_W-1:0] status;
    reg  [`SRSC_EV_W-1:0] mask;
    reg  [2:0]            diag;
    reg  [1:0]            wait_cnt;
    reg  [`SRSC_DOM_W-1:0] dom_seen;
    wire access = avs_read_in || avs_write_in;
    wire done   = access && (wait_cnt == `SRSC_WAIT_CYC);
    assign avs_waitrequest_out = access && !done;
    wire wr      = done && avs_write_in;
    wire rd      = done && avs_read_in;
    wire wr_sts  = wr && (avs_address_in == `SRSC_ADDR_STATUS);
    wire wr_msk  = wr && (avs_address_in == `SRSC_ADDR_MASK);
    wire wr_cmd  = wr && (avs_address_in == `SRSC_ADDR_CMD);
    wire rd_diag = rd && (avs_address_in == `SRSC_ADDR_DIAG);
    wire sw_rst  = wr_cmd && avs_writedata_in[`SRSC_CMD_SWRST];
    wire tnl_go  = wr_cmd && avs_writedata_in[`SRSC_CMD_TNL];

    wire [`SRSC_EV_W-1:0] ev_vec = {ev_wd, ev_pinl, ev_pins, ev_bov2, ev_bov1, ev_r5};
    genvar gi;
    generate
        for (gi = 0; gi < `SRSC_EV_W; gi = gi + 1) begin : g_sts
            always @(posedge sys_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    status[gi] <= 1'b0;
                end else if (ev_vec[gi]) begin
                    status[gi] <= 1'b1;
                end else if (wr_sts && avs_writedata_in[gi]) begin
                    status[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    assign irq_out = |(status & mask);

    // diagnostic flags: [0] reg5v, [1] battery, [2] watchdog
    // a read clears only what it returned, so an event in the wait state survives
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            diag <= 3'b000;
        end else begin
            diag[0] <= ev_r5 || (diag[0] && !(rd_diag && avs_readdata_out[0]));
            diag[1] <= ev_bov1 || ev_bov2 || (diag[1] && !(rd_diag && avs_readdata_out[1]));
            diag[2] <= ev_wd || (diag[2] && !(rd_diag && avs_readdata_out[2]));
        end
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask     <= {`SRSC_EV_W{1'b0}};
            wait_cnt <= 2'b00;
        end else begin
            if (wr_msk) begin
                mask <= avs_writedata_in[`SRSC_EV_W-1:0];
            end
            if (!access || done) begin
                wait_cnt <= 2'b00;
            end else begin
                wait_cnt <= wait_cnt + 2'd1;
            end
        end
    end

    // domain reset scopes, one pulse per event
    reg [`SRSC_DOM_W-1:0] scope;
    always @* begin
        scope = {`SRSC_DOM_W{1'b0}};
        if (ev_r5) begin
            scope[`SRSC_DOM_DRV]  = 1'b1;
            scope[`SRSC_DOM_WDOG] = 1'b1;
        end
        if (ev_bov1) begin
            scope[`SRSC_DOM_DRV]   = 1'b1;
            scope[`SRSC_DOM_LBDRV] = 1'b1;
            scope[`SRSC_DOM_WDOG]  = 1'b1;
        end
        if (ev_pins) begin
            scope[`SRSC_DOM_CFG]  = 1'b1;
            scope[`SRSC_DOM_DRV]  = 1'b1;
            scope[`SRSC_DOM_WDOG] = 1'b1;
            scope[`SRSC_DOM_XCVR] = 1'b1;
        end
        if (ev_pinl || ev_bov2 || sw_rst || tnl_go) begin
            scope = {`SRSC_DOM_W{1'b1}};
        end
        if (ev_wd) begin
            scope[`SRSC_DOM_DRV] = 1'b1;
        end
    end

    // latch exit pulse timer lives in the never-reset management domain
    reg [`SRSC_CNT_W-1:0] tnl_cnt;
    reg                   ov2_hold;
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tnl_cnt  <= {`SRSC_CNT_W{1'b0}};
            ov2_hold <= 1'b0;
            drive_low <= 1'b0;
        end else begin
            if (tnl_go) begin
                tnl_cnt <= `SRSC_TNL_CYC;
            end else if (tnl_cnt != {`SRSC_CNT_W{1'b0}}) begin
                tnl_cnt <= tnl_cnt - {{(`SRSC_CNT_W-1){1'b0}}, 1'b1};
            end
            if (ev_bov2) begin
                ov2_hold <= 1'b1;
            end else if (!bov) begin
                ov2_hold <= 1'b0;
            end
            drive_low <= tnl_go || (tnl_cnt > 32'd1) || ev_bov2 || (ov2_hold && bov);
        end
    end
    assign rst_pin_out    = 1'b0;
    assign rst_pin_oe_out = drive_low;

    // domain outputs; power management is touched only by vreg_off_out, set on long battery overvoltage
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_reset_out          <= 1'b0;
            drv_reset_out          <= 1'b0;
            lb_drv_reset_out       <= 1'b0;
            lb_cfg_reset_out       <= 1'b0;
            watchdog_reset_out     <= 1'b0;
            xcvr_reset_out         <= 1'b0;
            output_disable_bit_out <= 1'b1;
            vreg_off_out           <= 1'b0;
            dom_seen               <= {`SRSC_DOM_W{1'b0}};
        end else begin
            cfg_reset_out      <= scope[`SRSC_DOM_CFG];
            drv_reset_out      <= scope[`SRSC_DOM_DRV];
            lb_drv_reset_out   <= scope[`SRSC_DOM_LBDRV];
            lb_cfg_reset_out   <= scope[`SRSC_DOM_LBCFG];
            watchdog_reset_out <= scope[`SRSC_DOM_WDOG];
            xcvr_reset_out     <= scope[`SRSC_DOM_XCVR];
            if (scope[`SRSC_DOM_DRV] || scope[`SRSC_DOM_LBDRV]) begin
                output_disable_bit_out <= 1'b1;
            end else if (wr_cmd && avs_writedata_in[`SRSC_CMD_OUTEN]) begin
                output_disable_bit_out <= 1'b0;
            end
            vreg_off_out <= ov2_hold || ev_bov2;
            dom_seen     <= scope | (dom_seen & ~((wr && avs_address_in == `SRSC_ADDR_DOMAIN)
                            ? avs_writedata_in[`SRSC_DOM_W-1:0] : {`SRSC_DOM_W{1'b0}}));
        end
    end

    // captured in the wait state so the data already stand at the answer edge
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avs_readdata_out <= 32'h0;
        end else if (avs_read_in && !done) begin
            case (avs_address_in)
                `SRSC_ADDR_STATUS: avs_readdata_out <= {26'h0, status};
                `SRSC_ADDR_MASK:   avs_readdata_out <= {26'h0, mask};
                `SRSC_ADDR_DIAG:   avs_readdata_out <= {29'h0, diag};
                `SRSC_ADDR_CMD:    avs_readdata_out <= {25'h0, output_disable_bit_out, 4'h0, drive_low, ov2_hold};
                `SRSC_ADDR_DOMAIN: avs_readdata_out <= {26'h0, dom_seen};
                default:           avs_readdata_out <= 32'h0;
            endcase
        end
    end
endmodule // srsc_top
`default_nettype wire

/* pkg/srsc_consts.vh */
// constants and register map for the smart reset scope controller
`ifndef SRSC_CONSTS_VH
`define SRSC_CONSTS_VH

`define SRSC_CLK_MHZ        100
`define SRSC_TNL_US         2000
`define SRSC_TNL_CYC        (`SRSC_TNL_US * `SRSC_CLK_MHZ)
`define SRSC_RSTFLT_NS      10000
`define SRSC_RSTFLT_CYC     (`SRSC_RSTFLT_NS * `SRSC_CLK_MHZ / 1000)
`define SRSC_HOLD_CYC       32'd100000
`define SRSC_OV1_CYC        32'd1000
`define SRSC_OV2_CYC        32'd10000
`define SRSC_CNT_W          32

`define SRSC_ADDR_STATUS    4'h0
`define SRSC_ADDR_MASK      4'h1
`define SRSC_ADDR_DIAG      4'h2
`define SRSC_ADDR_CMD       4'h3
`define SRSC_ADDR_DOMAIN    4'h4

`define SRSC_EV_W           6
`define SRSC_EV_REG5V       0
`define SRSC_EV_BATOV1      1
`define SRSC_EV_BATOV2      2
`define SRSC_EV_PINSHORT    3
`define SRSC_EV_PINLONG     4
`define SRSC_EV_WDOG        5

`define SRSC_DOM_W          6
`define SRSC_DOM_CFG        0
`define SRSC_DOM_DRV        1
`define SRSC_DOM_LBDRV      2
`define SRSC_DOM_LBCFG      3
`define SRSC_DOM_WDOG       4
`define SRSC_DOM_XCVR       5

`define SRSC_CMD_SWRST      0
`define SRSC_CMD_TNL        1
`define SRSC_CMD_OUTEN      6
`define SRSC_WAIT_CYC       2'd1
`endif

/* verilog/srsc_filter.v */
// persistence counter: reports how long an input level has stood
`timescale 1ns/1ns
`default_nettype none
`include "srsc_consts.vh"
module srsc_filter (
    // clock and power-on reset
    input  wire                   sys_clk_in,
    input  wire                   resetn_in,
    // level already synchronised
    input  wire                   level_in,
    // elapsed cycles, saturating
    output reg  [`SRSC_CNT_W-1:0] count_out
);
    // power-on reset only, so a reset this times cannot cut itself short
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_out <= {`SRSC_CNT_W{1'b0}};
        end else if (!level_in) begin
            count_out <= {`SRSC_CNT_W{1'b0}};
        end else if (count_out != {`SRSC_CNT_W{1'b1}}) begin
            count_out <= count_out + {{(`SRSC_CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // srsc_filter
`default_nettype wire

/* bench/srsc_top_sva.sv */
// port assertions for the reset scope controller
`timescale 1ns/1ns
`default_nettype none
`include "srsc_consts.vh"
module srsc_chk (
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        resetn_in,
    // register bus
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic        avs_waitrequest_out,
    // events and pin
    input wire logic        reg5v_overvolt_in,
    input wire logic        battery_overvolt_in,
    input wire logic        watchdog_expire_in,
    input wire logic        rst_pin_n_in,
    input wire logic        rst_pin_oe_out,
    // domain resets, then output disable and regulator off
    input wire logic        cfg_reset_out,
    input wire logic        drv_reset_out,
    input wire logic        lb_drv_reset_out,
    input wire logic        lb_cfg_reset_out,
    input wire logic        watchdog_reset_out,
    input wire logic        xcvr_reset_out,
    input wire logic        output_disable_bit_out,
    input wire logic        vreg_off_out
);
    localparam int OV1 = `SRSC_OV1_CYC;
    localparam int OV2 = `SRSC_OV2_CYC;
    localparam int FLT = `SRSC_RSTFLT_CYC;
    localparam int HLD = `SRSC_HOLD_CYC;
    int bat_cnt;
    int pin_cnt;
    wire swr = avs_write_in && !avs_waitrequest_out && avs_address_in == `SRSC_ADDR_CMD && avs_writedata_in[0];
    wire tnl_w = avs_write_in && !avs_waitrequest_out && avs_address_in == `SRSC_ADDR_CMD
        && avs_writedata_in[`SRSC_CMD_TNL];
    wire all_rst = cfg_reset_out && drv_reset_out && lb_drv_reset_out && lb_cfg_reset_out && watchdog_reset_out
        && xcvr_reset_out;
    // raw run lengths; own pin drive is not an external hold
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bat_cnt <= 0;
            pin_cnt <= 0;
        end else begin
            bat_cnt <= battery_overvolt_in ? bat_cnt + 1 : 0;
            pin_cnt <= (!rst_pin_n_in && !rst_pin_oe_out) ? pin_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    a_swrst_all: assert property (swr |-> ##[1:4] all_rst)
        else $error("software reset missed a domain");
    a_swrst_nopin: assert property (swr |=> !$rose(rst_pin_oe_out) [*4])
        else $error("software reset drove the pin");
    a_swrst_power: assert property (swr |=> $stable(vreg_off_out) [*4])
        else $error("software reset touched power control");
    a_reg5v_scope: assert property ($rose(reg5v_overvolt_in) |-> ##[2:8] (drv_reset_out && watchdog_reset_out
        && !cfg_reset_out && !lb_drv_reset_out))
        else $error("regulator overvoltage scope wrong");
    a_wdog_scope: assert property ($rose(watchdog_expire_in) |-> ##[2:8] (drv_reset_out && !watchdog_reset_out
        && !cfg_reset_out))
        else $error("watchdog expiry scope wrong");
    a_drv_outdis: assert property ((drv_reset_out || lb_drv_reset_out) |-> ##[0:1] output_disable_bit_out)
        else $error("output disable not forced");
    a_batov_mid: assert property ($fell(battery_overvolt_in) && bat_cnt > OV1 + 4 && bat_cnt < OV2 - 4
        |-> ##[1:8] (drv_reset_out && lb_drv_reset_out && watchdog_reset_out && !cfg_reset_out))
        else $error("mid overvoltage scope wrong");
    a_batov_long: assert property ($rose(vreg_off_out) |-> bat_cnt >= OV2 ##[0:2] rst_pin_oe_out)
        else $error("long overvoltage timing or pin wrong");
    a_pin_short: assert property ($rose(rst_pin_n_in) && pin_cnt > FLT + 4 && pin_cnt < HLD - 4
        |-> ##[1:8] (cfg_reset_out && xcvr_reset_out && !lb_drv_reset_out))
        else $error("short pin hold scope wrong");
    a_pin_glitch: assert property ($rose(rst_pin_n_in) && pin_cnt > 0 && pin_cnt < FLT - 4
        |-> !cfg_reset_out [*8])
        else $error("pin glitch accepted as reset");
    a_tnl_pulse: assert property (tnl_w |=> rst_pin_oe_out [*8])
        else $error("latch exit pulse not driven");
    c_swrst: cover property (swr);
    c_batlong: cover property ($rose(vreg_off_out));
    c_wdog: cover property ($rose(watchdog_expire_in));
endmodule // srsc_chk
bind srsc_top srsc_chk u_srsc_chk (.*);
`default_nettype wire

/* bench/srsc_host.sv */
// host side of the reset pin: pull-up plus an external low hold
`timescale 1ns/1ns
`default_nettype none
module srsc_host (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    // hold command from the bench
    input  wire logic        hold_go_in,
    input  wire logic [19:0] hold_len_in,
    // device side of the pin
    input  wire logic        pin_drv_in,
    input  wire logic        pin_oe_in,
    output logic             pin_n_out
);
    logic [19:0] left;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            left <= 20'h0;
        else if (hold_go_in)
            left <= hold_len_in;
        else if (left != 20'h0)
            left <= left - 20'h1;
    end
    // pull-up wins unless either party pulls low
    assign pin_n_out = (left == 20'h0) && !(pin_oe_in && !pin_drv_in);
endmodule // srsc_host
`default_nettype wire

/* bench/srsc_top_tb.sv */
// self-checking bench for the reset scope controller
`timescale 1ns/1ns
`default_nettype none
`include "srsc_consts.vh"
module srsc_top_tb;
    logic        sys_clk_in = 0;
    logic        resetn_in = 0;
    logic [3:0]  av_addr = 0;
    logic        av_rd = 0, av_wr = 0, reg5v_ov = 0, bat_ov = 0, wdog_exp = 0, hold_go = 0, oe_seen = 0;
    logic [31:0] av_wdata = 0;
    logic [19:0] hold_len = 0;
    int          n_mismatch = 0;
    int          tests_run = 0;
    wire  [31:0] av_rdata;
    wire         av_wait, pin_n, pin_drv, pin_oe, irq, output_disable_bit, vreg_off;
    srsc_top u_srsc_top (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .avs_address_in(av_addr),
        .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
        .avs_waitrequest_out(av_wait), .reg5v_overvolt_in(reg5v_ov), .battery_overvolt_in(bat_ov),
        .watchdog_expire_in(wdog_exp), .rst_pin_n_in(pin_n), .rst_pin_out(pin_drv), .rst_pin_oe_out(pin_oe),
        .cfg_reset_out(), .drv_reset_out(), .lb_drv_reset_out(), .lb_cfg_reset_out(), .watchdog_reset_out(),
        .xcvr_reset_out(), .output_disable_bit_out(output_disable_bit), .vreg_off_out(vreg_off), .irq_out(irq));
    srsc_host u_srsc_host (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .hold_go_in(hold_go),
        .hold_len_in(hold_len), .pin_drv_in(pin_drv), .pin_oe_in(pin_oe), .pin_n_out(pin_n));
    initial forever #5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (pin_oe === 1'b1) oe_seen <= 1'b1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // request held until the edge that shows waitrequest low
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        int n;
        av_addr <= a;
        av_rd <= rd;
        av_wr <= !rd;
        av_wdata <= wd;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (av_wait !== 1'b0 && n < 64);
        if (n >= 64) chk(32'h1, 32'h0);
        // data taken at the answer edge; one idle edge before the next request
        d = av_rdata;
        av_rd <= 0;
        av_wr <= 0;
        @(posedge sys_clk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b0, a, wd, d);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b1, a, 32'h0, d);
        chk(d, exp);
    endtask
    task automatic judge(input logic [31:0] st, input logic [31:0] dom, input logic [31:0] dg);
        rdchk(`SRSC_ADDR_STATUS, st);
        rdchk(`SRSC_ADDR_DOMAIN, dom);
        rdchk(`SRSC_ADDR_DIAG, dg);
    endtask
    // diag is cleared by reading it
    task automatic clr;
        logic [31:0] d;
        wr(`SRSC_ADDR_STATUS, 32'h3F);
        wr(`SRSC_ADDR_DOMAIN, 32'h3F);
        wr(`SRSC_ADDR_CMD, 32'h40);
        xfer(1'b1, `SRSC_ADDR_DIAG, 32'h0, d);
        oe_seen = 0;
    endtask
    task automatic t_reg5v;
        clr();
        reg5v_ov <= 1;
        idle(50);
        reg5v_ov <= 0;
        idle(30);
        judge(32'h01, 32'h12, 32'h01);
        chk(32'(output_disable_bit), 32'h1);
        chk(32'(oe_seen), 32'h0);
    endtask
    task automatic t_bat_mid;
        clr();
        bat_ov <= 1;
        idle(3000);
        bat_ov <= 0;
        idle(30);
        judge(32'h02, 32'h16, 32'h02);
        chk(32'(oe_seen), 32'h0);
        rdchk(`SRSC_ADDR_DIAG, 32'h0);
    endtask
    task automatic t_pin;
        clr();
        hold_go <= 1;
        hold_len <= 20'd500;
        idle(1);
        hold_go <= 0;
        idle(530);
        judge(32'h0, 32'h0, 32'h0);
        hold_go <= 1;
        hold_len <= 20'd1500;
        idle(1);
        hold_go <= 0;
        idle(1530);
        judge(32'h08, 32'h33, 32'h0);
    endtask
    task automatic t_swrst;
        clr();
        wr(`SRSC_ADDR_CMD, 32'h1);
        idle(10);
        judge(32'h0, 32'h3F, 32'h0);
        chk(32'(oe_seen), 32'h0);
    endtask
    task automatic t_wdog;
        clr();
        wdog_exp <= 1;
        idle(20);
        wdog_exp <= 0;
        idle(30);
        judge(32'h20, 32'h02, 32'h04);
        chk(32'(output_disable_bit), 32'h1);
        chk(32'(irq), 32'h0);
        wr(`SRSC_ADDR_MASK, 32'h20);
        chk(32'(irq), 32'h1);
        wr(`SRSC_ADDR_STATUS, 32'h20);
        chk(32'(irq), 32'h0);
        rdchk(4'hF, 32'h0);
    endtask
    task automatic t_bat_long;
        clr();
        bat_ov <= 1;
        idle(10100);
        chk(32'(vreg_off), 32'h1);
        rdchk(`SRSC_ADDR_CMD, 32'h43);
        bat_ov <= 0;
        idle(50);
        judge(32'h04, 32'h3F, 32'h02);
    endtask
    // pulse outlasts the run, so only its start and survival are judged
    task automatic t_tnl;
        clr();
        wr(`SRSC_ADDR_CMD, 32'h2);
        chk(32'(pin_oe), 32'h1);
        chk(32'(pin_n), 32'h0);
        idle(1000);
        wr(`SRSC_ADDR_CMD, 32'h1);
        idle(1000);
        chk(32'(pin_oe), 32'h1);
        rdchk(`SRSC_ADDR_CMD, 32'h42);
        rdchk(`SRSC_ADDR_STATUS, 32'h0);
        rdchk(`SRSC_ADDR_DOMAIN, 32'h3F);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        idle(6);
        resetn_in <= 1;
        idle(1);
        t_reg5v();
        t_bat_mid();
        t_pin();
        t_swrst();
        t_wdog();
        t_bat_long();
        t_tnl();
        wrap_up();
    end
    // scenarios need about 18000 cycles
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
endmodule // srsc_top_tb
`default_nettype wire
